// *** verilog/sbp_regs.svh ***
// register map, index codes and source codes of the bit packer / unpacker
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH

// register byte addresses
`define A_WR_IDX 8'h00
`define A_RD_IDX 8'h04
`define A_SRC 8'h08
`define A_UNP_SRC 8'h0C
`define A_PACKED 8'h10
`define A_UNPACKED 8'h14
`define A_STATUS 8'h18

// write / read index codes
`define IDX_ALL_NV 6'h00
`define IDX_ONE_NV_FIRST 6'h01
`define IDX_ONE_NV_LAST 6'h10
`define IDX_ALL_VOL 6'h11
`define IDX_ONE_VOL_FIRST 6'h12
`define IDX_MAX 6'h21
`define IDX_RESET 6'h01

// packer source codes
`define SRC_ON 10'h006
`define SRC_OFF 10'h007

// unpacker source codes
`define UNP_ZERO 10'h009
`define UNP_RX_FIRST 10'h2C0
`define UNP_RX_LAST 10'h2D7
`define UNP_REM_CTRL 10'h2E4
`define UNP_REM_STATE 10'h2E5
`define UNP_FB_FIRST 10'h2F2
`define UNP_FB_LAST 10'h2F5
`define UNP_CTRL_STAT 10'h384
`define UNP_PACKED 10'h39F

// sizes
`define NUM_IN 16
`define POOL_W 1024
`define LAST_ENTRY 4'hF

`endif

// *** verilog/sbp_pkg.sv ***
// types shared by the bit packer / unpacker modules
package sbp_pkg;
    typedef logic [9:0] sel_t;
    typedef enum logic [0:0] {
        ld_idle = 1'b0,
        ld_copy = 1'b1
    } ld_state_t;
endpackage

// *** verilog/sel_if.sv ***
// carrier between the register core and the selection store
`timescale 1ns/10ps
`default_nettype none
interface sel_if;
    logic wr_en;
    logic [5:0] wr_idx;
    sbp_pkg::sel_t wr_sel;
    logic [5:0] rd_idx;
    sbp_pkg::sel_t rd_sel;
    sbp_pkg::sel_t work [16];
    logic loading;
    modport store (input wr_en, input wr_idx, input wr_sel, input rd_idx,
                   output rd_sel, output work, output loading);
    modport core (output wr_en, output wr_idx, output wr_sel, output rd_idx,
                  input rd_sel, input work, input loading);
endinterface
`default_nettype wire

// *** verilog/sel_store.sv ***
// persistent and working stores of the sixteen packer source selections
`timescale 1ns/10ps
`default_nettype none
`include "sbp_regs.svh"
module sel_store (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic factory_rst_n,
    sel_if.store io
);
    sbp_pkg::sel_t nv_q [16];
    sbp_pkg::sel_t work_q [16];
    logic [3:0] ld_cnt_q;
    sbp_pkg::ld_state_t ld_q;

    // ****************************************
    // power-up reload of working store
    // ****************************************
    // rst_n stands for a power cycle: the working copy is rebuilt from the
    // persistent store, so volatile-only edits are lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_q <= sbp_pkg::ld_copy;
            ld_cnt_q <= 4'h0;
        end else begin
            case (ld_q)
                sbp_pkg::ld_copy: begin
                    ld_cnt_q <= 4'(ld_cnt_q + 4'h1);
                    if (ld_cnt_q == `LAST_ENTRY) begin
                        ld_q <= sbp_pkg::ld_idle;
                    end
                end
                sbp_pkg::ld_idle: begin
                    ld_cnt_q <= 4'h0;
                end
                default: begin
                    ld_q <= sbp_pkg::ld_idle;
                end
            endcase
        end
    end

    assign io.loading = (ld_q == sbp_pkg::ld_copy);

    // ****************************************
    // per-entry storage
    // ****************************************
    for (genvar g = 0; g < `NUM_IN; g++) begin : g_entry
        localparam logic [5:0] NV_IDX = 6'(g) + `IDX_ONE_NV_FIRST;
        localparam logic [5:0] VOL_IDX = 6'(g) + `IDX_ONE_VOL_FIRST;
        localparam logic [3:0] ENTRY = 4'(g);
        // persistent store survives rst_n; only a factory reset clears it
        always_ff @(posedge clk or negedge factory_rst_n) begin
            if (!factory_rst_n) begin
                nv_q[g] <= `SRC_OFF;
            end else if (io.wr_en && (io.wr_idx == `IDX_ALL_NV || io.wr_idx == NV_IDX)) begin
                nv_q[g] <= io.wr_sel;
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                work_q[g] <= `SRC_OFF;
            end else if (io.loading && ld_cnt_q == ENTRY) begin
                work_q[g] <= nv_q[g];
            end else if (io.wr_en && (io.wr_idx == `IDX_ALL_NV || io.wr_idx == NV_IDX
                         || io.wr_idx == `IDX_ALL_VOL || io.wr_idx == VOL_IDX)) begin
                work_q[g] <= io.wr_sel;
            end
        end
        assign io.work[g] = work_q[g];
    end

    // ****************************************
    // read-back
    // ****************************************
    // persistent indices read the stored value, volatile ones the working copy
    always_comb begin
        io.rd_sel = `SRC_OFF;
        if (io.rd_idx == `IDX_ALL_NV) begin
            io.rd_sel = nv_q[0];
        end else if (io.rd_idx <= `IDX_ONE_NV_LAST) begin
            io.rd_sel = nv_q[4'(io.rd_idx - `IDX_ONE_NV_FIRST)];
        end else if (io.rd_idx == `IDX_ALL_VOL) begin
            io.rd_sel = work_q[0];
        end else if (io.rd_idx <= `IDX_MAX) begin
            io.rd_sel = work_q[4'(io.rd_idx - `IDX_ONE_VOL_FIRST)];
        end
    end
endmodule
`default_nettype wire

// *** verilog/signal_bit_pack_unpack.sv ***
// sixteen-signal bit packer and sixteen-bit unpacker with an APB register port
//
// Behaviour
// - sixteen packer inputs, each selectable from any internal or digital signal.
// - the sixteen inputs form one packed word, source code 927, for transmit data.
// - write and read index selectors, range 0 to 33, default 1.
// - write index 0 updates every entry in persistent and working store.
// - indices 0 to 16 store persistently, surviving a power cycle.
// - indices 17 to 33 change working store only; power-up reloads persistent values.
// - index 17 writes all entries volatile; 18 to 33 write entry 1 to 16.
// - a selection written to index 0 is copied to all entries.
// - unpacker takes one 16-bit word chosen from received or internal words.
// - legal unpack sources: 9, 704-727, 740, 741, 754-757, 900, 927.
// - unpacked word bits 0 to 15 appear as signals 910 to 925 ascending.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sbp_regs.svh"
module signal_bit_pack_unpack (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic factory_rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1023:0] sig_pool,
    input wire logic [383:0] rx_words,
    input wire logic [15:0] remote_ctrl_word,
    input wire logic [15:0] remote_state_word,
    input wire logic [63:0] fb_out_words,
    input wire logic [15:0] ctrl_status,
    output logic [15:0] packed_word,
    output logic [15:0] unpacked_bits
);
    sel_if io ();

    logic [5:0] wr_idx_q;
    logic [5:0] rd_idx_q;
    sbp_pkg::sel_t unsrc_q;
    logic [15:0] packed_q;
    logic [15:0] packed_d;
    logic [15:0] unpacked_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    logic err_d;
    logic access;
    logic wr_ok;
    logic idx_bad;
    logic src_bad;

    sel_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .factory_rst_n(factory_rst_n),
        .io(io.store)
    );

    // ****************************************
    // unpacker source check and word pick
    // ****************************************
    function automatic logic unp_legal(input sbp_pkg::sel_t c);
        unp_legal = (c == `UNP_ZERO)
            || (c >= `UNP_RX_FIRST && c <= `UNP_RX_LAST)
            || (c == `UNP_REM_CTRL) || (c == `UNP_REM_STATE)
            || (c >= `UNP_FB_FIRST && c <= `UNP_FB_LAST)
            || (c == `UNP_CTRL_STAT) || (c == `UNP_PACKED);
    endfunction

    function automatic logic [15:0] unp_pick(input sbp_pkg::sel_t c);
        logic [9:0] rx_off;
        logic [9:0] fb_off;
        rx_off = 10'(c - `UNP_RX_FIRST);
        fb_off = 10'(c - `UNP_FB_FIRST);
        unp_pick = 16'h0000;
        if (c >= `UNP_RX_FIRST && c <= `UNP_RX_LAST) begin
            unp_pick = rx_words[{rx_off[4:0], 4'h0} +: 16];
        end else if (c == `UNP_REM_CTRL) begin
            unp_pick = remote_ctrl_word;
        end else if (c == `UNP_REM_STATE) begin
            unp_pick = remote_state_word;
        end else if (c >= `UNP_FB_FIRST && c <= `UNP_FB_LAST) begin
            unp_pick = fb_out_words[{fb_off[1:0], 4'h0} +: 16];
        end else if (c == `UNP_CTRL_STAT) begin
            unp_pick = ctrl_status;
        end else if (c == `UNP_PACKED) begin
            unp_pick = packed_q;
        end
    endfunction

    // ****************************************
    // packer
    // ****************************************
    for (genvar b = 0; b < `NUM_IN; b++) begin : g_pack
        always_comb begin
            if (io.work[b] == `SRC_OFF) begin
                packed_d[b] = 1'b0;
            end else if (io.work[b] == `SRC_ON) begin
                packed_d[b] = 1'b1;
            end else begin
                packed_d[b] = sig_pool[io.work[b]];
            end
        end
    end

    // one cycle of latency keeps the loop through code 927 registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            packed_q <= 16'h0000;
        end else begin
            packed_q <= packed_d;
        end
    end

    // ****************************************
    // unpacker
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unpacked_q <= 16'h0000;
        end else begin
            unpacked_q <= unp_pick(unsrc_q);
        end
    end

    assign packed_word = packed_q;
    // bit 0 is unpacked_bit_first, bit 15 unpacked_bit_last
    assign unpacked_bits = unpacked_q;

    // ****************************************
    // APB decode
    // ****************************************
    // the store is busy for sixteen cycles after reset; the bus waits
    assign pready = !io.loading;
    assign access = psel && penable && pready;
    assign idx_bad = (pwdata[31:6] != 26'h0000000) || (pwdata[5:0] > `IDX_MAX);
    assign src_bad = (pwdata[31:10] != 22'h000000) || !unp_legal(pwdata[9:0]);

    always_comb begin
        err_d = 1'b0;
        prdata_d = 32'h00000000;
        case (paddr)
            `A_WR_IDX: begin
                err_d = pwrite && idx_bad;
                prdata_d = {26'h0000000, wr_idx_q};
            end
            `A_RD_IDX: begin
                err_d = pwrite && idx_bad;
                prdata_d = {26'h0000000, rd_idx_q};
            end
            `A_SRC: begin
                err_d = pwrite && (pwdata[31:10] != 22'h000000);
                prdata_d = {22'h000000, io.rd_sel};
            end
            `A_UNP_SRC: begin
                err_d = pwrite && src_bad;
                prdata_d = {22'h000000, unsrc_q};
            end
            `A_PACKED: begin
                err_d = pwrite;
                prdata_d = {16'h0000, packed_q};
            end
            `A_UNPACKED: begin
                err_d = pwrite;
                prdata_d = {16'h0000, unpacked_q};
            end
            `A_STATUS: begin
                err_d = pwrite;
                prdata_d = {31'h00000000, io.loading};
            end
            default: begin
                err_d = 1'b1;
            end
        endcase
    end

    assign wr_ok = access && pwrite && !err_d;

    // answer data is captured during setup and wait, then held for access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else if (psel && !access) begin
            prdata_q <= pwrite ? 32'h00000000 : prdata_d;
            err_q <= err_d;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = err_q && psel && penable;

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_q <= `IDX_RESET;
        end else if (wr_ok && paddr == `A_WR_IDX) begin
            wr_idx_q <= pwdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_idx_q <= `IDX_RESET;
        end else if (wr_ok && paddr == `A_RD_IDX) begin
            rd_idx_q <= pwdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unsrc_q <= `UNP_ZERO;
        end else if (wr_ok && paddr == `A_UNP_SRC) begin
            unsrc_q <= pwdata[9:0];
        end
    end

    assign io.wr_en = wr_ok && (paddr == `A_SRC);
    assign io.wr_idx = wr_idx_q;
    assign io.wr_sel = pwdata[9:0];
    assign io.rd_idx = rd_idx_q;

    // ****************************************
    // assertions
    // ****************************************
    localparam int LOAD_MAX = 17;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_idx_range;
        (wr_idx_q <= `IDX_MAX) && (rd_idx_q <= `IDX_MAX);
    endproperty
    a_idx_range: assert property (p_idx_range) else $error("index out of range");

    property p_all_both;
        (io.wr_en && io.wr_idx == `IDX_ALL_NV)
        |=> (io.work[0] == $past(io.wr_sel)) && (io.work[15] == $past(io.wr_sel));
    endproperty
    a_all_both: assert property (p_all_both) else $error("index 0 write not spread");

    property p_copy_all;
        (io.wr_en && io.wr_idx == `IDX_ALL_NV && rd_idx_q == `IDX_ONE_NV_LAST)
        |=> (io.rd_sel == $past(io.wr_sel));
    endproperty
    a_copy_all: assert property (p_copy_all) else $error("index 0 not copied to last");

    property p_vol_all;
        (io.wr_en && io.wr_idx == `IDX_ALL_VOL)
        |=> (io.work[0] == $past(io.wr_sel)) && (io.work[15] == $past(io.wr_sel));
    endproperty
    a_vol_all: assert property (p_vol_all) else $error("index 17 write not spread");

    property p_vol_keep_nv;
        (io.wr_en && io.wr_idx == `IDX_ALL_VOL && rd_idx_q == `IDX_ALL_NV)
        |=> $stable(io.rd_sel);
    endproperty
    a_vol_keep_nv: assert property (p_vol_keep_nv) else $error("volatile write hit store");

    property p_vol_first;
        (io.wr_en && io.wr_idx == `IDX_ONE_VOL_FIRST)
        |=> (io.work[0] == $past(io.wr_sel));
    endproperty
    a_vol_first: assert property (p_vol_first) else $error("index 18 missed entry 1");

    property p_load_done;
        io.loading |-> ##[0:LOAD_MAX] !io.loading;
    endproperty
    a_load_done: assert property (p_load_done) else $error("reload never ends");

    property p_off_zero;
        ($past(io.work[3]) == `SRC_OFF) |-> (packed_q[3] == 1'b0);
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("off input not zero");

    property p_bit_place;
        ($past(io.work[15]) != `SRC_OFF && $past(io.work[15]) != `SRC_ON)
        |-> (packed_q[15] == $past(sig_pool[io.work[15]]));
    endproperty
    a_bit_place: assert property (p_bit_place) else $error("packed bit misplaced");

    property p_unp_local;
        (unsrc_q == `UNP_PACKED) ##1 (unsrc_q == `UNP_PACKED)
        |-> (unpacked_bits == $past(packed_word));
    endproperty
    a_unp_local: assert property (p_unp_local) else $error("local loop word wrong");

    property p_unp_zero;
        (unsrc_q == `UNP_ZERO) |=> (unpacked_bits == 16'h0000);
    endproperty
    a_unp_zero: assert property (p_unp_zero) else $error("zero source not zero");

    property p_bad_src;
        (access && pwrite && paddr == `A_UNP_SRC && src_bad)
        |-> pslverr ##1 $stable(unsrc_q);
    endproperty
    a_bad_src: assert property (p_bad_src) else $error("illegal source taken");

    property p_idx_reject;
        (access && pwrite && paddr == `A_WR_IDX && idx_bad)
        |-> pslverr ##1 $stable(wr_idx_q);
    endproperty
    a_idx_reject: assert property (p_idx_reject) else $error("bad index taken");

    property p_nv_single;
        (io.wr_en && io.wr_idx == `IDX_ONE_NV_FIRST)
        |=> (io.work[0] == $past(io.wr_sel));
    endproperty
    a_nv_single: assert property (p_nv_single) else $error("index 1 missed working copy");

    property p_vol_skip_first;
        (io.wr_en && io.wr_idx > `IDX_ONE_VOL_FIRST)
        |=> $stable(io.work[0]);
    endproperty
    a_vol_skip_first: assert property (p_vol_skip_first) else $error("entry 1 hit");

    property p_on_one;
        ($past(io.work[0]) == `SRC_ON) |-> packed_q[0];
    endproperty
    a_on_one: assert property (p_on_one) else $error("on input not one");

    property p_ro_reject;
        (access && pwrite && paddr == `A_PACKED) |-> pslverr;
    endproperty
    a_ro_reject: assert property (p_ro_reject) else $error("packed word written");

    c_wr_all_nv: cover property (io.wr_en && io.wr_idx == `IDX_ALL_NV);
    c_vol_single: cover property (io.wr_en && io.wr_idx > `IDX_ALL_VOL);
    c_unp_local: cover property (unsrc_q == `UNP_PACKED && packed_q != 16'h0000);
    c_load_end: cover property ($fell(io.loading));
endmodule
`default_nettype wire

// *** verification/bus_partner.sv ***
// far-side process data channel model feeding the unpacker word inputs
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] packed_word,
    output logic [383:0] rx_words,
    output logic [15:0] remote_ctrl_word,
    output logic [15:0] remote_state_word,
    output logic [63:0] fb_out_words,
    output logic [15:0] ctrl_status
);
    logic [15:0] loop_q;
    // ****************************************
    // transmit slot looped into receive word 0
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_q <= 16'h0000;
        end else begin
            loop_q <= packed_word;
        end
    end
    // every fixed word differs from its neighbours so a wrong pick shows
    always_comb begin
        rx_words[15:0] = loop_q;
        for (int k = 1; k < 24; k++) begin
            rx_words[16*k +: 16] = 16'h5A00 | 16'(k);
        end
        for (int k = 0; k < 4; k++) begin
            fb_out_words[16*k +: 16] = 16'h0F00 | 16'(k);
        end
        remote_ctrl_word = 16'hC3A1;
        remote_state_word = 16'h3C5E;
        ctrl_status = 16'h8421;
    end
endmodule
`default_nettype wire

// *** verification/tb_signal_bit_pack_unpack.sv ***
// self-checking bench of the bit packer / unpacker over its register port
`timescale 1ns/10ps
`default_nettype none
`include "sbp_regs.svh"
module tb_signal_bit_pack_unpack;
    logic clk, rst_n, factory_rst_n, psel, penable, pwrite, pready, pslverr, ev;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [1023:0] sig_pool;
    logic [383:0] rx_words;
    logic [15:0] remote_ctrl_word, remote_state_word, ctrl_status;
    logic [15:0] packed_word, unpacked_bits;
    logic [63:0] fb_out_words;
    logic [9:0] uc [10];
    logic [15:0] ue [10];
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    signal_bit_pack_unpack signal_bit_pack_unpack_i (.clk(clk), .rst_n(rst_n),
        .factory_rst_n(factory_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sig_pool(sig_pool), .rx_words(rx_words),
        .remote_ctrl_word(remote_ctrl_word), .remote_state_word(remote_state_word),
        .fb_out_words(fb_out_words), .ctrl_status(ctrl_status),
        .packed_word(packed_word), .unpacked_bits(unpacked_bits));
    bus_partner bus_partner_i (.clk(clk), .rst_n(rst_n), .packed_word(packed_word),
        .rx_words(rx_words), .remote_ctrl_word(remote_ctrl_word),
        .remote_state_word(remote_state_word), .fb_out_words(fb_out_words),
        .ctrl_status(ctrl_status));
    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the whole sequence needs well under two thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    // ****************************************
    // access tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // entered just after a rising edge; answer taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check({31'h0, ev}, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b0, a, 32'h0);
        check({31'h0, ev}, {31'h0, e});
        check(rdv, d);
    endtask
    task automatic wait_chk(input int n, input logic unp, input logic [15:0] exp);
        repeat (n) @(posedge clk);
        @(negedge clk);
        check({16'h0, unp ? unpacked_bits : packed_word}, {16'h0, exp});
        @(posedge clk);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        uc = '{10'h009, 10'h2C1, 10'h2D7, 10'h2E4, 10'h2E5, 10'h2F2, 10'h2F5,
               10'h384, 10'h39F, 10'h2C0};
        ue = '{16'h0000, 16'h5A01, 16'h5A17, 16'hC3A1, 16'h3C5E, 16'h0F00,
               16'h0F03, 16'h8421, 16'hA5C1, 16'hA5C1};
        rst_n = 1'b0;
        factory_rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sig_pool = '0;
        // decoys: pool bits under the on/off codes are the opposite of the codes
        sig_pool[7] = 1'b1;
        for (int n = 1; n <= 16; n++) begin
            sig_pool[100 + n] = 1'(16'hA5C3 >> (n - 1));
        end
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        factory_rst_n <= 1'b1;
        @(posedge clk);
        rd(`A_WR_IDX, 32'h1, 1'b0);
        rd(`A_RD_IDX, 32'h1, 1'b0);
        rd(`A_UNP_SRC, 32'h9, 1'b0);
        rd(`A_STATUS, 32'h0, 1'b0);
        rd(`A_PACKED, 32'h0, 1'b0);
        wr(`A_WR_IDX, 32'h0, 1'b0);
        wr(`A_RD_IDX, 32'h10, 1'b0);
        wr(`A_SRC, 32'h6, 1'b0);
        wait_chk(2, 1'b0, 16'hFFFF);
        rd(`A_SRC, 32'h6, 1'b0);
        wr(`A_RD_IDX, 32'h1A, 1'b0);
        rd(`A_SRC, 32'h6, 1'b0);
        for (int n = 1; n <= 16; n++) begin
            wr(`A_WR_IDX, n, 1'b0);
            wr(`A_SRC, 100 + n, 1'b0);
        end
        wait_chk(2, 1'b0, 16'hA5C3);
        wr(`A_WR_IDX, 32'h2, 1'b0);
        wr(`A_SRC, 32'h7, 1'b0);
        wait_chk(2, 1'b0, 16'hA5C1);
        wr(`A_RD_IDX, 32'h0, 1'b0);
        wr(`A_WR_IDX, 32'h11, 1'b0);
        wr(`A_SRC, 32'h6, 1'b0);
        wait_chk(2, 1'b0, 16'hFFFF);
        rd(`A_SRC, 32'h65, 1'b0);
        wr(`A_WR_IDX, 32'h16, 1'b0);
        wr(`A_SRC, 32'h7, 1'b0);
        wait_chk(2, 1'b0, 16'hFFEF);
        wr(`A_WR_IDX, 32'h12, 1'b0);
        wr(`A_SRC, 32'h7, 1'b0);
        wait_chk(2, 1'b0, 16'hFFEE);
        wr(`A_RD_IDX, 32'h5, 1'b0);
        rd(`A_SRC, 32'h69, 1'b0);
        wr(`A_RD_IDX, 32'h16, 1'b0);
        rd(`A_SRC, 32'h7, 1'b0);
        wr(`A_RD_IDX, 32'h0, 1'b0);
        rd(`A_SRC, 32'h65, 1'b0);
        wr(`A_RD_IDX, 32'h11, 1'b0);
        rd(`A_SRC, 32'h7, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // the answer is latched in the last wait cycle, while the reload still ran
        rd(`A_STATUS, 32'h1, 1'b0);
        rd(`A_STATUS, 32'h0, 1'b0);
        wait_chk(2, 1'b0, 16'hA5C1);
        rd(`A_PACKED, 32'hA5C1, 1'b0);
        rd(`A_WR_IDX, 32'h1, 1'b0);
        wr(`A_WR_IDX, 32'h22, 1'b1);
        rd(`A_WR_IDX, 32'h1, 1'b0);
        wr(`A_PACKED, 32'h0, 1'b1);
        rd(8'h1C, 32'h0, 1'b1);
        wr(`A_SRC, 32'h400, 1'b1);
        wr(`A_UNP_SRC, 32'h2D8, 1'b1);
        rd(`A_UNP_SRC, 32'h9, 1'b0);
        for (int i = 0; i < 10; i++) begin
            wr(`A_UNP_SRC, 32'(uc[i]), 1'b0);
            wait_chk(3, 1'b1, ue[i]);
        end
        rd(`A_UNPACKED, 32'hA5C1, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
